/* bench/tcc_timer_tb.sv */
/*
 * Self-checking bench for the 16-bit timer with compare output unit:
 * reset state, forced output actions, pin override, normal wrap, both
 * clear-on-match modes and the match block after a counter write.
 * Assumes the register map and latencies of the timer package and that
 * the assertions live in the design files.
 */
module tcc_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;    // System clock.
	logic        reset;      // Synchronous reset.
	logic [7:0]  reg_addr;   // Register address.
	logic [31:0] reg_wdata;  // Write data.
	logic        reg_wr;     // Write strobe.
	logic        reg_rd;     // Read strobe.
	logic [31:0] reg_rdata;  // Read data.
	logic        irq_ack;    // Overflow service pulse.
	logic [1:0]  pin_out;    // Pin levels.
	logic [1:0]  pin_oe;     // Pin enables.
	logic        irq_ovf;    // Overflow request.
	int          err_total;  // Mismatches.
	int          n_tests;    // Comparisons.
	int          m_cnt;      // Model counter.
	int          m_st;       // Model output state of channel A.
	int          m_ovf;      // Model overflow flag.
	int          m_ma;       // Model match flag A.
	int          m_mb;       // Model match flag B.
	logic [1:0]  coms [5];   // Action sequence for the force test.

	tcc_timer uut (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.irq_ack   (irq_ack),
		.pin_out   (pin_out),
		.pin_oe    (pin_oe),
		.irq_ovf   (irq_ovf)
	);

	// Free-running 100 MHz clock.
	always #5 clk_sys = ~clk_sys;

	// Closing report, the single place where the run ends.
	task automatic end_sim();
		if (err_total == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t pin got %h exp %h", $time, got, exp);
		end
	endtask : chk_pin

	// One write cycle; the gap cycle keeps strobes from being set twice.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr

	// Read data are only valid in the cycle after the strobe.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		chk_reg(reg_rdata, exp);
	endtask : rd_chk

	// Pins are registered one cycle behind the state they show.
	task automatic pin_chk(input logic [1:0] eo, input logic [1:0] ee);
		repeat (2) @(posedge clk_sys);
		#1;
		chk_pin(pin_out, eo);
		chk_pin(pin_oe, ee);
	endtask : pin_chk

	// Expected port word: out B high, dir A as given, state A.
	function automatic logic [31:0] port_word(input int dir);
		return 32'(2 | (dir << 2) | (m_st << 4));
	endfunction : port_word

	// Counter model over n running edges; channel A toggles on a match.
	task automatic run_model(input int mode, input int cmpa,
		input int top, input int n);
		for (int i = 0; i < n; i++) begin
			if (m_cnt == cmpa) begin
				m_ma = 1;
				m_st = m_st ^ 1;
			end
			if (m_cnt == 0) m_mb = 1;
			if ((mode == 4 && m_cnt == cmpa) || (mode == 12 && m_cnt == top))
				m_cnt = 0;
			else begin
				if (m_cnt == 65535) m_ovf = 1;
				m_cnt = (m_cnt + 1) % 65536;
			end
		end
	endtask : run_model

	// Run the timer k+2 edges in one mode, stop it and compare all results.
	task automatic run_case(input int mode, input int start, input int cmpa,
		input int top, input int k);
		logic [31:0] ctl;
		ctl = 32'(mode | (1 << 5) | (32'(tcc_timer_pkg::COM_TOGGLE) << 8));
		wr(tcc_timer_pkg::OFS_FLAGS, 32'h0000_0007);
		wr(tcc_timer_pkg::OFS_COUNT, 32'(start));
		wr(tcc_timer_pkg::OFS_CMPA, 32'(cmpa));
		wr(tcc_timer_pkg::OFS_CAPT, 32'(top));
		wr(tcc_timer_pkg::OFS_CTRL, ctl | 32'h0000_0010);
		repeat (k) @(posedge clk_sys);
		wr(tcc_timer_pkg::OFS_CTRL, ctl);
		m_cnt = start;
		m_ovf = 0;
		m_ma  = 0;
		m_mb  = 0;
		run_model(mode, cmpa, top, k + 2);
		rd_chk(tcc_timer_pkg::OFS_COUNT, 32'(m_cnt));
		rd_chk(tcc_timer_pkg::OFS_FLAGS,
			32'(m_ovf | (m_ma << 1) | (m_mb << 2)));
		rd_chk(tcc_timer_pkg::OFS_PORT, port_word(1));
		rd_chk(tcc_timer_pkg::OFS_CAPT, 32'(top));
		pin_chk({1'b1, 1'(m_st)}, 2'h1);
		chk_pin({1'b0, irq_ovf}, 2'(m_ovf));
		@(posedge clk_sys);
		irq_ack <= 1'b1;
		@(posedge clk_sys);
		irq_ack <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk_pin({1'b0, irq_ovf}, 2'h0);
		rd_chk(tcc_timer_pkg::OFS_FLAGS, 32'((m_ma << 1) | (m_mb << 2)));
	endtask : run_case

	// Main sequence.
	initial begin
		clk_sys   = 1'b0;
		reset     = 1'b1;
		reg_addr  = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		irq_ack   = 1'b0;
		err_total = 0;
		n_tests   = 0;
		m_st      = 0;
		void'($urandom(32'hbb79e52c));
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		rd_chk(tcc_timer_pkg::OFS_PORT, 32'h0000_0000);
		rd_chk(tcc_timer_pkg::OFS_CTRL, 32'h0000_0000);
		rd_chk(tcc_timer_pkg::OFS_COUNT, 32'h0000_0000);
		rd_chk(8'h20, 32'h0000_0000);
		pin_chk(2'h0, 2'h0);
		// Forced actions while the pin is still an input.
		coms = '{tcc_timer_pkg::COM_TOGGLE, tcc_timer_pkg::COM_CLEAR,
			tcc_timer_pkg::COM_SET, tcc_timer_pkg::COM_NONE,
			tcc_timer_pkg::COM_CLEAR};
		wr(tcc_timer_pkg::OFS_PORT, 32'h0000_0002);
		foreach (coms[i]) begin
			wr(tcc_timer_pkg::OFS_CTRL, 32'(coms[i]) << 8);
			rd_chk(tcc_timer_pkg::OFS_PORT, port_word(0));
			wr(tcc_timer_pkg::OFS_FORCE, 32'h0000_0001);
			case (coms[i])
				tcc_timer_pkg::COM_TOGGLE: m_st = m_st ^ 1;
				tcc_timer_pkg::COM_CLEAR:  m_st = 0;
				tcc_timer_pkg::COM_SET:    m_st = 1;
				default:                   m_st = m_st;
			endcase
			rd_chk(tcc_timer_pkg::OFS_PORT, port_word(0));
		end
		pin_chk(2'h2, 2'h0);
		// Prepare the state high, then make the pin an output.
		wr(tcc_timer_pkg::OFS_CTRL, 32'(tcc_timer_pkg::COM_SET) << 8);
		wr(tcc_timer_pkg::OFS_FORCE, 32'h0000_0001);
		m_st = 1;
		wr(tcc_timer_pkg::OFS_PORT, 32'h0000_0006);
		pin_chk(2'h3, 2'h1);
		wr(tcc_timer_pkg::OFS_CTRL, 32'h0000_0000);
		pin_chk(2'h2, 2'h1);
		// Normal wrap passing compare A, then both clear-on-match modes.
		run_case(0, 32'hfff0, 5, 0, 28);
		run_case(4, 0, 2 + ($urandom % 8), 0, 10 + ($urandom % 30));
		run_case(12, 0, 2, 3 + ($urandom % 7), 10 + ($urandom % 30));
		// Counter write while running: the write lands and blocks a match.
		wr(tcc_timer_pkg::OFS_FLAGS, 32'h0000_0007);
		wr(tcc_timer_pkg::OFS_CMPA, 32'h0000_0040);
		wr(tcc_timer_pkg::OFS_COUNT, 32'h0000_0010);
		wr(tcc_timer_pkg::OFS_CTRL, 32'h0000_0110);
		wr(tcc_timer_pkg::OFS_COUNT, 32'h0000_0040);
		repeat (3) @(posedge clk_sys);
		wr(tcc_timer_pkg::OFS_CTRL, 32'h0000_0100);
		rd_chk(tcc_timer_pkg::OFS_COUNT, 32'h0000_0045);
		rd_chk(tcc_timer_pkg::OFS_FLAGS, 32'h0000_0000);
		rd_chk(tcc_timer_pkg::OFS_PORT, port_word(1));
		// Mode bits zero: a real match at 0x40 sets flag A, state holds.
		wr(tcc_timer_pkg::OFS_COUNT, 32'h0000_003e);
		wr(tcc_timer_pkg::OFS_CTRL, 32'h0000_0010);
		repeat (4) @(posedge clk_sys);
		wr(tcc_timer_pkg::OFS_CTRL, 32'h0000_0000);
		rd_chk(tcc_timer_pkg::OFS_COUNT, 32'h0000_0044);
		rd_chk(tcc_timer_pkg::OFS_FLAGS, 32'h0000_0002);
		rd_chk(tcc_timer_pkg::OFS_PORT, port_word(1));
		// Channel B: its compare value, and a force that the PWM waveform
		// mode 1 ignores but normal mode applies.
		wr(tcc_timer_pkg::OFS_CMPB, 32'h0000_1234);
		rd_chk(tcc_timer_pkg::OFS_CMPB, 32'h0000_1234);
		wr(tcc_timer_pkg::OFS_CTRL, 32'h0000_0c01);
		wr(tcc_timer_pkg::OFS_FORCE, 32'h0000_0003);
		rd_chk(tcc_timer_pkg::OFS_PORT, port_word(1));
		wr(tcc_timer_pkg::OFS_CTRL, 32'h0000_0c00);
		wr(tcc_timer_pkg::OFS_FORCE, 32'h0000_0002);
		rd_chk(tcc_timer_pkg::OFS_PORT, port_word(1) | 32'h0000_0020);
		end_sim();
	end

	// Watchdog: a run that overstays its bound counts as a mismatch.
	initial begin
		repeat (100000) @(posedge clk_sys);
		err_total++;
		end_sim();
	end

endmodule : tcc_timer_tb

/* verilog/tcc_timer.sv */
/*
 * 16-bit timer/counter: normal and clear-on-match counting, two compare
 * channels with their compare output state, port pin override, overflow
 * flag and overflow interrupt request.
 * Assumes a single-cycle register master on clk_sys that never issues a
 * read and a write in the same cycle. The PWM action tables are not built:
 * in any other waveform mode the counter runs as in normal mode and the
 * output states hold.
 */
// The address map and the address-and-strobe port were chosen for this implementation.

//Contract
// - Reset clears every compare output state to zero.
// - Output state is an internal register; pin shows it only under override.
// - Nonzero mode bits replace the port output value with the output state.
// - Pin direction stays with the port direction bit during override.
// - Output state may be set up before the pin is made an output.
// - Mode bits zero means no action on the state at a match.
// - Mode bits never influence input capture behaviour.
// - New mode bits act first at the next match after the write.
// - Force strobe applies the configured action at once in non-PWM modes.
// - Counting sequence depends only on the waveform mode bits.
// - Non-PWM mode bits select set, clear or toggle on a match.
// - Normal mode always increments and is never cleared by a match.
// - Normal mode wraps from the 16-bit maximum to zero.
// - Overflow flag sets in the cycle the counter becomes zero.
// - Counting only sets the overflow flag; servicing clears it.
// - Normal mode accepts a counter write at any time.
// - Mode 4 clears on compare value A, mode 12 on capture value.
// - Clear-on-match mode counts up to the top value, then clears.
// - A counter write blocks every compare match in the next cycle.
module tcc_timer #(
	parameter int CNT_W = 16,                 // Counter width.
	parameter int N_CH  = 2                   // Compare channels.
) (
	input  wire logic             clk_sys,    // System clock, 100 MHz.
	input  wire logic             reset,      // Synchronous reset, high.
	input  wire logic [7:0]       reg_addr,   // Register byte address.
	input  wire logic [31:0]      reg_wdata,  // Write data.
	input  wire logic             reg_wr,     // Write strobe.
	input  wire logic             reg_rd,     // Read strobe.
	output logic      [31:0]      reg_rdata,  // Read data, cycle after rd.
	input  wire logic             irq_ack,    // Overflow service pulse.
	output logic      [N_CH-1:0]  pin_out,    // Pin output level.
	output logic      [N_CH-1:0]  pin_oe,     // Pin output enable.
	output logic                  irq_ovf     // Overflow interrupt request.
);

	localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
	localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

	// Software-visible state.
	logic [3:0]       mode_r;
	logic             run_r;
	logic             ovie_r;
	logic [1:0]       com_r [N_CH];
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] cmp_r [N_CH];
	logic [CNT_W-1:0] capt_r;
	logic [N_CH-1:0]  port_out_r;
	logic [N_CH-1:0]  dir_r;
	logic [N_CH-1:0]  oc_state_r;
	logic             ovf_flag_r;
	logic [N_CH-1:0]  match_flag_r;
	logic             block_r;
	logic [31:0]      rdata_r;
	logic [N_CH-1:0]  pin_out_r;
	logic [N_CH-1:0]  pin_oe_r;
	logic             irq_r;

	// Decoded strobes and events.
	logic             wr_ctrl;
	logic             wr_count;
	logic             wr_flags;
	logic             wr_force;
	logic             wr_port;
	logic             non_pwm;
	logic             top_hit;
	logic             wrap;
	logic [N_CH-1:0]  match_evt;
	logic [N_CH-1:0]  force_evt;

	// Action on the output state for a given mode setting.
	function automatic logic oc_action(input logic [1:0] com,
			input logic cur);
		case (com)
			tcc_timer_pkg::COM_TOGGLE: oc_action = ~cur;
			tcc_timer_pkg::COM_CLEAR:  oc_action = 1'b0;
			tcc_timer_pkg::COM_SET:    oc_action = 1'b1;
			default:                   oc_action = cur;
		endcase
	endfunction : oc_action

	// Address decode of the write strobes.
	assign wr_ctrl  = reg_wr && reg_addr == tcc_timer_pkg::OFS_CTRL;
	assign wr_count = reg_wr && reg_addr == tcc_timer_pkg::OFS_COUNT;
	assign wr_flags = reg_wr && reg_addr == tcc_timer_pkg::OFS_FLAGS;
	assign wr_force = reg_wr && reg_addr == tcc_timer_pkg::OFS_FORCE;
	assign wr_port  = reg_wr && reg_addr == tcc_timer_pkg::OFS_PORT;

	// Only normal and clear-on-match modes accept forced actions.
	assign non_pwm = mode_r == tcc_timer_pkg::MODE_NORMAL
		|| mode_r == tcc_timer_pkg::MODE_CTC_CMPA
		|| mode_r == tcc_timer_pkg::MODE_CTC_CAPT;

	// Matches count only while running and not blocked by a counter write.
	always_comb begin
		for (int i = 0; i < N_CH; i++) begin
			match_evt[i] = run_r && !block_r && cnt_r == cmp_r[i];
			force_evt[i] = wr_force && non_pwm && reg_wdata[i];
		end
	end

	// Top match in clear-on-match mode; mode bits alone choose the top.
	always_comb begin
		case (mode_r)
			tcc_timer_pkg::MODE_CTC_CMPA:
				top_hit = run_r && !block_r && cnt_r == cmp_r[0];
			tcc_timer_pkg::MODE_CTC_CAPT:
				top_hit = run_r && !block_r && cnt_r == capt_r;
			default:
				top_hit = 1'b0;
		endcase
	end

	// Overflow happens when counting carries out of the maximum value.
	assign wrap = run_r && !wr_count && !top_hit && cnt_r == CNT_MAX;

	// Next counter value: a write wins, then the top clear, then counting.
	always_comb begin
		if (wr_count) begin
			cnt_nxt = reg_wdata[CNT_W-1:0];
		end else if (!run_r) begin
			cnt_nxt = cnt_r;
		end else if (top_hit) begin
			cnt_nxt = CNT_ZERO;
		end else begin
			cnt_nxt = cnt_r + CNT_ONE;
		end
	end

	// Counter register.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_r <= CNT_ZERO;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// A counter write masks matches in the following cycle, running or not.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			block_r <= tcc_timer_pkg::RST_BIT;
		end else begin
			block_r <= wr_count;
		end
	end

	// Control register: mode, run, interrupt enable, output modes.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mode_r <= tcc_timer_pkg::RST_WORD[3:0];
			run_r  <= tcc_timer_pkg::RST_BIT;
			ovie_r <= tcc_timer_pkg::RST_BIT;
			for (int i = 0; i < N_CH; i++) begin
				com_r[i] <= tcc_timer_pkg::COM_NONE;
			end
		end else if (wr_ctrl) begin
			mode_r <= reg_wdata[tcc_timer_pkg::CTRL_MODE_LSB +:
				tcc_timer_pkg::CTRL_MODE_W];
			run_r  <= reg_wdata[tcc_timer_pkg::CTRL_RUN_BIT];
			ovie_r <= reg_wdata[tcc_timer_pkg::CTRL_OVIE_BIT];
			// Not buffered: a new setting governs the very next match.
			for (int i = 0; i < N_CH; i++) begin
				com_r[i] <= reg_wdata[tcc_timer_pkg::CTRL_COMA_LSB +
					i * tcc_timer_pkg::COM_W +: tcc_timer_pkg::COM_W];
			end
		end
	end

	// Compare and capture values, written directly.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			capt_r <= CNT_ZERO;
			for (int i = 0; i < N_CH; i++) begin
				cmp_r[i] <= CNT_ZERO;
			end
		end else if (reg_wr) begin
			if (reg_addr == tcc_timer_pkg::OFS_CAPT) begin
				capt_r <= reg_wdata[CNT_W-1:0];
			end
			if (reg_addr == tcc_timer_pkg::OFS_CMPA) begin
				cmp_r[0] <= reg_wdata[CNT_W-1:0];
			end
			if (reg_addr == tcc_timer_pkg::OFS_CMPB && N_CH > 1) begin
				cmp_r[N_CH-1] <= reg_wdata[CNT_W-1:0];
			end
		end
	end

	// General port value and direction bits for the compare pins.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			port_out_r <= '0;
			dir_r      <= '0;
		end else if (wr_port) begin
			port_out_r <= reg_wdata[tcc_timer_pkg::PORT_OUT_LSB +: N_CH];
			dir_r      <= reg_wdata[tcc_timer_pkg::PORT_DIR_LSB +: N_CH];
		end
	end

	// Compare output state. It is kept apart from the pin, so software can
	// prepare it with a force while the pin is still an input.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			oc_state_r <= '0;
		end else begin
			for (int i = 0; i < N_CH; i++) begin
				if (force_evt[i] || (match_evt[i] && non_pwm)) begin
					oc_state_r[i] <= oc_action(com_r[i],
						oc_state_r[i]);
				end
			end
		end
	end

	// Overflow flag: counting only sets it; service or a one clears it.
	// A set in the same cycle as a clear wins, so no overflow is lost.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ovf_flag_r <= tcc_timer_pkg::RST_BIT;
		end else if (wrap) begin
			ovf_flag_r <= 1'b1;
		end else if (irq_ack || (wr_flags &&
				reg_wdata[tcc_timer_pkg::FLG_OVF_BIT])) begin
			ovf_flag_r <= 1'b0;
		end
	end

	// Match flags, set on a match and cleared by writing a one.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			match_flag_r <= '0;
		end else begin
			for (int i = 0; i < N_CH; i++) begin
				if (match_evt[i]) begin
					match_flag_r[i] <= 1'b1;
				end else if (wr_flags &&
						reg_wdata[tcc_timer_pkg::FLG_MATCH_LSB + i]) begin
					match_flag_r[i] <= 1'b0;
				end
			end
		end
	end

	// Pin drive: the override swaps only the level, never the direction.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_out_r <= '0;
			pin_oe_r  <= '0;
		end else begin
			for (int i = 0; i < N_CH; i++) begin
				pin_out_r[i] <= (com_r[i] != tcc_timer_pkg::COM_NONE) ?
					oc_state_r[i] : port_out_r[i];
			end
			pin_oe_r <= dir_r;
		end
	end

	// Interrupt request follows the flag gated by its enable.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_r <= tcc_timer_pkg::RST_BIT;
		end else begin
			irq_r <= ovf_flag_r && ovie_r;
		end
	end

	// Read data stand only in the cycle after the strobe; else zero.
	always_ff @(posedge clk_sys) begin
		if (reset || !reg_rd) begin
			rdata_r <= tcc_timer_pkg::RST_WORD;
		end else begin
			rdata_r <= '0;
			case (reg_addr)
				tcc_timer_pkg::OFS_CTRL: begin
					rdata_r[tcc_timer_pkg::CTRL_MODE_LSB +:
						tcc_timer_pkg::CTRL_MODE_W] <= mode_r;
					rdata_r[tcc_timer_pkg::CTRL_RUN_BIT]  <= run_r;
					rdata_r[tcc_timer_pkg::CTRL_OVIE_BIT] <= ovie_r;
					for (int i = 0; i < N_CH; i++) begin
						rdata_r[tcc_timer_pkg::CTRL_COMA_LSB +
							i * tcc_timer_pkg::COM_W +:
							tcc_timer_pkg::COM_W] <= com_r[i];
					end
				end
				tcc_timer_pkg::OFS_COUNT: rdata_r[CNT_W-1:0] <= cnt_r;
				tcc_timer_pkg::OFS_CMPA:  rdata_r[CNT_W-1:0] <= cmp_r[0];
				tcc_timer_pkg::OFS_CMPB:
					rdata_r[CNT_W-1:0] <= cmp_r[N_CH-1];
				tcc_timer_pkg::OFS_CAPT:  rdata_r[CNT_W-1:0] <= capt_r;
				tcc_timer_pkg::OFS_FLAGS: begin
					rdata_r[tcc_timer_pkg::FLG_OVF_BIT] <= ovf_flag_r;
					rdata_r[tcc_timer_pkg::FLG_MATCH_LSB +: N_CH] <=
						match_flag_r;
				end
				tcc_timer_pkg::OFS_PORT: begin
					rdata_r[tcc_timer_pkg::PORT_OUT_LSB +: N_CH] <= port_out_r;
					rdata_r[tcc_timer_pkg::PORT_DIR_LSB +: N_CH] <= dir_r;
					rdata_r[tcc_timer_pkg::PORT_OC_LSB +: N_CH]  <= oc_state_r;
				end
				default: rdata_r <= '0;
			endcase
		end
	end

	// Outputs come straight from flip-flops.
	assign reg_rdata = rdata_r;
	assign pin_out   = pin_out_r;
	assign pin_oe    = pin_oe_r;
	assign irq_ovf   = irq_r;

	// Checks on the behaviour above.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_ctc_top;
		mode_r == tcc_timer_pkg::MODE_CTC_CMPA && run_r && !block_r
			&& !wr_count && cnt_r == cmp_r[0];
	endsequence

	sequence s_normal_max;
		mode_r == tcc_timer_pkg::MODE_NORMAL && run_r && !wr_count
			&& cnt_r == CNT_MAX;
	endsequence

	chk_reset_state: assert property (disable iff (1'b0)
		reset |=> oc_state_r == '0)
		else $error("Output state not cleared by reset.");

	chk_pin_override: assert property (
		com_r[0] != tcc_timer_pkg::COM_NONE |=>
			pin_out_r[0] == $past(oc_state_r[0]))
		else $error("Pin does not show the output state.");

	chk_dir_kept: assert property (
		wr_port ##1 1'b1 |=> pin_oe_r ==
			$past(reg_wdata[tcc_timer_pkg::PORT_DIR_LSB +: N_CH], 2))
		else $error("Pin direction not taken from direction bits.");

	chk_idle_action: assert property (
		match_evt[0] && com_r[0] == tcc_timer_pkg::COM_NONE
			&& !force_evt[0] |=> $stable(oc_state_r[0]))
		else $error("Output state changed with mode bits zero.");

	chk_force_clear: assert property (
		force_evt[0] && com_r[0] == tcc_timer_pkg::COM_CLEAR
			|=> !oc_state_r[0])
		else $error("Forced clear did not take effect.");

	chk_normal_wrap: assert property (
		s_normal_max |=> cnt_r == CNT_ZERO && ovf_flag_r)
		else $error("Normal wrap or overflow flag wrong.");

	chk_ovf_sticky: assert property (
		ovf_flag_r && !irq_ack && !wr_flags |=> ovf_flag_r)
		else $error("Overflow flag dropped without service.");

	chk_ctc_clear: assert property (
		s_ctc_top |=> cnt_r == CNT_ZERO ##1 cnt_r == CNT_ONE || !run_r
			|| block_r || $past(wr_count) || wr_count)
		else $error("Clear-on-match did not restart from zero.");

	chk_write_block: assert property (
		wr_count |=> match_evt == '0 && !top_hit)
		else $error("Match not blocked after counter write.");

	chk_irq_follow: assert property (
		ovf_flag_r && ovie_r |=> irq_r)
		else $error("Overflow request missing.");

endmodule : tcc_timer

/* verilog/tcc_timer_pkg.sv */
/*
 * Package for the 16-bit timer/counter with compare output unit: register
 * offsets, field positions, mode and action encodings, reset values.
 * Assumes a plain register port with 32-bit data and byte addresses.
 */
package tcc_timer_pkg;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_CMPA  = 8'h08;
	localparam logic [7:0] OFS_CMPB  = 8'h0c;
	localparam logic [7:0] OFS_CAPT  = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_FORCE = 8'h18;
	localparam logic [7:0] OFS_PORT  = 8'h1c;

	// Control register fields.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_W   = 4;
	localparam int CTRL_RUN_BIT  = 4;
	localparam int CTRL_OVIE_BIT = 5;
	localparam int CTRL_COMA_LSB = 8;
	localparam int CTRL_COMB_LSB = 10;
	localparam int COM_W         = 2;

	// Flag register fields; the match flags follow the overflow flag.
	localparam int FLG_OVF_BIT   = 0;
	localparam int FLG_MATCH_LSB = 1;

	// Port register fields.
	localparam int PORT_OUT_LSB = 0;
	localparam int PORT_DIR_LSB = 2;
	localparam int PORT_OC_LSB  = 4;

	// Waveform modes handled here: normal and the two clear-on-match modes.
	localparam logic [3:0] MODE_NORMAL   = 4'h0;
	localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
	localparam logic [3:0] MODE_CTC_CAPT = 4'hc;

	// Compare output actions in the non-PWM modes.
	localparam logic [1:0] COM_NONE   = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	// Reset values.
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic        RST_BIT  = 1'b0;

endpackage : tcc_timer_pkg
